// [rtl/fplsc_pkg.sv]
// package: constants for the flash power, lock and suspend controller
package fplsc_pkg;
  // apb register byte offsets
  localparam logic [11:0] STAT2_OFS   = 12'h000;
  localparam logic [11:0] STAT3_OFS   = 12'h004;
  localparam logic [11:0] STAT4_OFS   = 12'h008;
  localparam logic [11:0] STAT5_OFS   = 12'h00c;
  localparam logic [11:0] LOCK_OFS    = 12'h010;
  localparam logic [11:0] RSTPWR_OFS  = 12'h014;
  // field positions
  localparam int ANY_SUSPEND_FLAG_BIT   = 7;  // any_suspend_flag, second status reg
  localparam int RSTEN_BIT  = 7;  // reset pin enable, third status reg
  localparam int PDM_BIT    = 7;  // powerdown_level_select, fourth_status_reg
  localparam int PE_BIT     = 5;  // program_error_flag
  localparam int EE_BIT     = 4;  // erase_error_flag
  localparam int ES_BIT     = 3;  // erase_suspended_flag, fifth status reg
  localparam int PS_BIT     = 2;  // program_suspended_flag
  localparam int JRST_BIT   = 0;  // jedec reset trigger
  localparam int BUSY_BIT   = 4;  // busy view in reset/power reg
  // reset values
  localparam logic [15:0] LOCK_RST  = 16'h0000;
  localparam logic        RSTEN_RST = 1'b0;
  localparam logic        PDM_RST   = 1'b0;
  // opcodes
  localparam logic [7:0] OP_LOCK_A  = 8'h3c;
  localparam logic [7:0] OP_LOCK_B  = 8'h3d;
  localparam logic [7:0] OP_PD      = 8'hb9;
  localparam logic [7:0] OP_PD_DEEP = 8'h79;
  localparam logic [7:0] OP_RESUME  = 8'hab;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_TERM    = 8'hf0;
  localparam logic [7:0] OP_ANY_SUSPEND_FLAG_A  = 8'hb0;
  localparam logic [7:0] OP_ANY_SUSPEND_FLAG_B  = 8'h75;
  localparam logic [7:0] OP_RESM_A  = 8'hd0;
  localparam logic [7:0] OP_RESM_B  = 8'h7a;
  // spi frame bit counts
  localparam logic [5:0] OPC_BITS   = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h20;
  localparam logic [3:0] LOCK_BITS  = 4'h8;
  // timing, ns and derived cycles at 4 ns
  localparam int CLK_NS          = 4;
  localparam int PROG_TIME_NS    = 2000;
  localparam int ERASE_TIME_NS   = 8000;
  localparam int LIGHT_WAKE_NS   = 1000;
  localparam int DEEP_WAKE_NS    = 100000;
  localparam logic [15:0] PROG_CYC  = 16'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ERASE_CYC = 16'((ERASE_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] LIGHT_WAKE_CYC =
    16'((LIGHT_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam int DEEP_WAKE_CYC = (DEEP_WAKE_NS + CLK_NS - 1) / CLK_NS;
  // power state, gray along active->light->deep->wake
  typedef enum logic [1:0] {
    PW_ACTIVE = 2'b00,
    PW_LIGHT  = 2'b01,
    PW_DEEP   = 2'b11,
    PW_WAKE   = 2'b10
  } fplsc_pwr_t;
endpackage

// [rtl/fplsc_top.sv]
// module: spi command control for lock read, power-down, resets and suspend
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fplsc_top #(
  parameter int DEEP_WAKE_CYC = fplsc_pkg::DEEP_WAKE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        reset_pin_n,
  output logic             so,
  output logic             so_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  typedef struct packed {
    logic                 sck_m, sck_q, sck_d;
    logic                 cs_m, cs_q, cs_d;
    logic                 si_m, si_q;
    logic                 rp_m, rp_q;
    logic [5:0]           bit_cnt;
    logic [31:0]          sh_in;
    logic [7:0]           opcode;
    logic [3:0]           blk;
    logic [7:0]           so_sh;
    logic [3:0]           out_cnt;
    logic                 so;
    logic                 so_oe;
    logic                 rst_armed;
    fplsc_pkg::fplsc_pwr_t pwr;
    logic                 wake_reset;
    logic [15:0]          wake_cnt;
    logic                 prog_act, prog_pause, erase_act, erase_pause;
    logic                 ps, es, pe, ee;
    logic [15:0]          prog_cnt, erase_cnt;
    logic                 rst_en;
    logic                 powerdown_level_select;
    logic [15:0]          lock;
    logic [31:0]          prdata;
  } fplsc_state_t;
  fplsc_state_t r;
  fplsc_state_t next_r;
  logic        sck_rise, sck_fall, cs_rise, cs_low, exec1, exec_addr;
  logic        is_prog, is_erase, is_chip, busy, any_suspend, apb_wr;
  logic        mapped, pd_now, soft_rst, jedec_rst, pin_rst;
  logic [31:0] rd_val;
  // edges seen only on the second and third synchroniser stages
  assign sck_rise  = r.sck_q & ~r.sck_d;
  assign sck_fall  = ~r.sck_q & r.sck_d;
  assign cs_rise   = r.cs_q & ~r.cs_d;
  assign cs_low    = ~r.cs_q;
  assign exec1     = cs_rise & (r.bit_cnt == fplsc_pkg::OPC_BITS);
  assign exec_addr = cs_rise & (r.bit_cnt >= fplsc_pkg::ADDR_BITS);
  assign pd_now    = (r.pwr != fplsc_pkg::PW_ACTIVE);
  // opcode classes for operation starts and lock checks
  always_comb begin
    unique case (r.opcode)
      8'h02, 8'ha2, 8'h32, 8'had, 8'haf, 8'h9b: is_prog = 1'b1;
      default:                                  is_prog = 1'b0;
    endcase
    unique case (r.opcode)
      8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7: is_erase = 1'b1;
      default:                           is_erase = 1'b0;
    endcase
    is_chip = (r.opcode == 8'h60) || (r.opcode == 8'hc7);
  end
  assign busy        = (r.prog_act & ~r.prog_pause) |
                       (r.erase_act & ~r.erase_pause);
  assign any_suspend = r.es | r.ps;
  // apb: zero wait, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign mapped  = (paddr[31:12] == 20'h00000) &&
                   (paddr[11:0] <= fplsc_pkg::RSTPWR_OFS) &&
                   (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = r.prdata;
  assign so      = r.so;
  assign so_oe   = r.so_oe;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (mapped) begin
      unique case (paddr[11:0])
        fplsc_pkg::STAT2_OFS: rd_val[fplsc_pkg::ANY_SUSPEND_FLAG_BIT] = any_suspend;
        fplsc_pkg::STAT3_OFS: rd_val[fplsc_pkg::RSTEN_BIT] = r.rst_en;
        fplsc_pkg::STAT4_OFS: begin
          rd_val[fplsc_pkg::PDM_BIT] = r.powerdown_level_select;
          rd_val[fplsc_pkg::PE_BIT]  = r.pe;
          rd_val[fplsc_pkg::EE_BIT]  = r.ee;
        end
        fplsc_pkg::STAT5_OFS: begin
          rd_val[fplsc_pkg::ES_BIT] = r.es;
          rd_val[fplsc_pkg::PS_BIT] = r.ps;
        end
        fplsc_pkg::LOCK_OFS: rd_val[15:0] = r.lock;
        fplsc_pkg::RSTPWR_OFS: begin
          rd_val[1:0]                = r.pwr;
          rd_val[fplsc_pkg::BUSY_BIT] = busy;
        end
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end
  // reset sources other than power-on
  assign jedec_rst = apb_wr && mapped &&
                     (paddr[11:0] == fplsc_pkg::RSTPWR_OFS) &&
                     pwdata[fplsc_pkg::JRST_BIT];
  assign pin_rst   = ~r.rp_q & r.rst_en; // pin only counts once enabled
  assign soft_rst  = exec1 & (r.opcode == fplsc_pkg::OP_RST) & r.rst_armed &
                     ((r.pwr == fplsc_pkg::PW_ACTIVE) ||
                      (r.pwr == fplsc_pkg::PW_LIGHT));
  always_comb begin
    next_r = r;
    // synchronisers, first stage read only by the second
    next_r.sck_m = sck;
    next_r.sck_q = r.sck_m;
    next_r.sck_d = r.sck_q;
    next_r.cs_m  = cs_n;
    next_r.cs_q  = r.cs_m;
    next_r.cs_d  = r.cs_q;
    next_r.si_m  = si;
    next_r.si_q  = r.si_m;
    next_r.rp_m  = reset_pin_n;
    next_r.rp_q  = r.rp_m;
    // apb register writes and read capture
    if (psel & ~penable) begin
      next_r.prdata = rd_val;
    end
    if (apb_wr && mapped) begin
      unique case (paddr[11:0])
        fplsc_pkg::STAT3_OFS: next_r.rst_en = pwdata[fplsc_pkg::RSTEN_BIT];
        fplsc_pkg::STAT4_OFS: next_r.powerdown_level_select = pwdata[fplsc_pkg::PDM_BIT];
        fplsc_pkg::LOCK_OFS:  next_r.lock = pwdata[15:0];
        default: ;
      endcase
    end
    // operation timers; completion clears the matching suspend flag
    if (r.prog_act & ~r.prog_pause) begin
      if (r.prog_cnt == 16'h0000) begin
        next_r.prog_act = 1'b0;
        next_r.ps       = 1'b0;
      end else begin
        next_r.prog_cnt = r.prog_cnt - 16'h0001;
      end
    end
    if (r.erase_act & ~r.erase_pause) begin
      if (r.erase_cnt == 16'h0000) begin
        next_r.erase_act = 1'b0;
        next_r.es        = 1'b0;
      end else begin
        next_r.erase_cnt = r.erase_cnt - 16'h0001;
      end
    end
    // wake recovery; deepest exit ends with an internal reset
    if (r.pwr == fplsc_pkg::PW_WAKE) begin
      if (r.wake_cnt == 16'h0000) begin
        next_r.pwr = fplsc_pkg::PW_ACTIVE;
      end else begin
        next_r.wake_cnt = r.wake_cnt - 16'h0001;
      end
    end
    // serial input shift on sck rise while selected
    if (cs_low & sck_rise) begin
      next_r.sh_in = {r.sh_in[30:0], r.si_q};
      if (r.bit_cnt != 6'h3f) begin
        next_r.bit_cnt = r.bit_cnt + 6'h01;
      end
      if (r.bit_cnt == fplsc_pkg::OPC_BITS - 6'h01) begin
        next_r.opcode = {r.sh_in[6:0], r.si_q};
      end
      if (r.bit_cnt == fplsc_pkg::ADDR_BITS - 6'h01) begin
        next_r.blk = r.sh_in[18:15];
        // lock field load, only while awake
        if (((r.opcode == fplsc_pkg::OP_LOCK_A) ||
             (r.opcode == fplsc_pkg::OP_LOCK_B)) && !pd_now) begin
          next_r.so_sh   = {7'h00, r.lock[r.sh_in[18:15]]};
          next_r.out_cnt = fplsc_pkg::LOCK_BITS;
          next_r.so_oe   = 1'b1;
        end
      end
    end
    // lock field out on sck fall, msb first
    if (cs_low & sck_fall & (r.out_cnt != 4'h0)) begin
      next_r.so      = r.so_sh[7];
      next_r.so_sh   = {r.so_sh[6:0], 1'b0};
      next_r.out_cnt = r.out_cnt - 4'h1;
    end
    // command execution at chip select rise
    if (cs_rise) begin
      next_r.bit_cnt = 6'h00;
      next_r.out_cnt = 4'h0;
      next_r.so_oe   = 1'b0;
      if (exec1) begin
        next_r.rst_armed = (r.opcode == fplsc_pkg::OP_RST_EN) &&
                           (r.pwr != fplsc_pkg::PW_DEEP);
      end
      // power-down levels accept only their exits; cs rise alone is nothing
      unique case (r.pwr)
        fplsc_pkg::PW_LIGHT, fplsc_pkg::PW_DEEP: begin
          if (exec1 && (r.opcode == fplsc_pkg::OP_RESUME)) begin
            next_r.pwr        = fplsc_pkg::PW_WAKE;
            next_r.wake_reset = (r.pwr == fplsc_pkg::PW_DEEP);
            next_r.wake_cnt   = (r.pwr == fplsc_pkg::PW_DEEP) ?
                                16'(DEEP_WAKE_CYC) :
                                fplsc_pkg::LIGHT_WAKE_CYC;
          end
        end
        fplsc_pkg::PW_WAKE: ;
        fplsc_pkg::PW_ACTIVE: begin
          if (exec1 && !busy) begin
            if (r.opcode == fplsc_pkg::OP_PD) begin
              next_r.pwr = r.powerdown_level_select ? fplsc_pkg::PW_LIGHT
                                 : fplsc_pkg::PW_DEEP;
            end else if (r.opcode == fplsc_pkg::OP_PD_DEEP) begin
              next_r.pwr = fplsc_pkg::PW_DEEP;
            end
          end
          // suspend: program first if running; one ending now is done
          if (exec1 && ((r.opcode == fplsc_pkg::OP_ANY_SUSPEND_FLAG_A) ||
                        (r.opcode == fplsc_pkg::OP_ANY_SUSPEND_FLAG_B))) begin
            if (next_r.prog_act & ~r.prog_pause) begin
              next_r.prog_pause = 1'b1;
              next_r.ps         = 1'b1;
            end else if (next_r.erase_act & ~r.erase_pause) begin
              next_r.erase_pause = 1'b1;
              next_r.es          = 1'b1;
            end
          end
          // resume: innermost suspended operation first
          if (exec1 && ((r.opcode == fplsc_pkg::OP_RESM_A) ||
                        (r.opcode == fplsc_pkg::OP_RESM_B))) begin
            if (r.prog_pause) begin
              next_r.prog_pause = 1'b0;
            end else if (r.erase_pause & ~r.prog_act) begin
              next_r.erase_pause = 1'b0;
            end
          end
          // terminate halts the running operation, no reset
          if (exec1 && (r.opcode == fplsc_pkg::OP_TERM)) begin
            if (r.prog_act & ~r.prog_pause) begin
              next_r.prog_act = 1'b0;
              next_r.ps       = 1'b0;
              next_r.pe       = 1'b1;
            end else if (r.erase_act & ~r.erase_pause) begin
              next_r.erase_act = 1'b0;
              next_r.es        = 1'b0;
              next_r.ee        = 1'b1;
            end
          end
          // program may start with no erase active or beside a suspended erase
          if (exec_addr && is_prog && !r.prog_act &&
              (!r.erase_act || r.erase_pause) && !r.lock[r.blk]) begin
            next_r.prog_act = 1'b1;
            next_r.prog_cnt = fplsc_pkg::PROG_CYC;
            next_r.pe       = 1'b0;
          end
          // erase never starts under a suspended program
          if (exec_addr && is_erase && !r.prog_act && !r.erase_act &&
              !(is_chip ? |r.lock : r.lock[r.blk])) begin
            next_r.erase_act = 1'b1;
            next_r.erase_cnt = fplsc_pkg::ERASE_CYC;
            next_r.ee        = 1'b0;
          end
        end
      endcase
    end
    // resets abort operations and leave power-down; last so they win
    if (soft_rst || jedec_rst || pin_rst ||
        ((r.pwr == fplsc_pkg::PW_WAKE) && r.wake_reset &&
         (r.wake_cnt == 16'h0000))) begin
      next_r.prog_act    = 1'b0;
      next_r.prog_pause  = 1'b0;
      next_r.erase_act   = 1'b0;
      next_r.erase_pause = 1'b0;
      next_r.ps          = 1'b0;
      next_r.es          = 1'b0;
      next_r.pe          = 1'b0;
      next_r.ee          = 1'b0;
      next_r.rst_armed   = 1'b0;
      next_r.wake_reset  = 1'b0;
      next_r.out_cnt     = 4'h0;
      next_r.so_oe       = 1'b0;
      next_r.pwr         = fplsc_pkg::PW_ACTIVE;
    end
  end
  // single state register; power-on reset via presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.cs_m   <= 1'b1;
      r.cs_q   <= 1'b1;
      r.cs_d   <= 1'b1;
      r.rp_m   <= 1'b1;
      r.rp_q   <= 1'b1;
      r.rst_en <= fplsc_pkg::RSTEN_RST;
      r.powerdown_level_select    <= fplsc_pkg::PDM_RST;
      r.lock   <= fplsc_pkg::LOCK_RST;
      r.pwr    <= fplsc_pkg::PW_ACTIVE;
    end else begin
      r <= next_r;
    end
  end

  property p_lock_load;
    (cs_low && sck_rise && r.bit_cnt == 6'h1f && !pd_now &&
     (r.opcode == 8'h3c || r.opcode == 8'h3d))
    |=> (r.so_sh == {7'h00, r.lock[r.blk]}) && r.so_oe && r.out_cnt == 4'h8;
  endproperty
  a_lock_load: assert property (p_lock_load)
    else $error("lock field not loaded after address");
  property p_lock_refuse;
    (exec_addr && is_prog && !r.prog_act && r.lock[r.blk] && !pd_now)
    |=> !r.prog_act;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("program started on locked block");
  property p_light;
    (exec1 && r.opcode == 8'hb9 && r.powerdown_level_select && !busy && !pd_now &&
     !jedec_rst && !pin_rst) |=> (r.pwr == fplsc_pkg::PW_LIGHT);
  endproperty
  a_light: assert property (p_light)
    else $error("b9 with select set did not enter light level");
  property p_deep;
    (exec1 && !busy && !pd_now && !jedec_rst && !pin_rst &&
     (r.opcode == 8'h79 || (r.opcode == 8'hb9 && !r.powerdown_level_select)))
    |=> (r.pwr == fplsc_pkg::PW_DEEP);
  endproperty
  a_deep: assert property (p_deep)
    else $error("deepest level not entered");
  property p_term_stay;
    (cs_rise && (r.pwr == fplsc_pkg::PW_LIGHT || r.pwr == fplsc_pkg::PW_DEEP)
     && r.opcode != 8'hab && r.opcode != 8'h99 && !jedec_rst && !pin_rst)
    |=> $stable(r.pwr);
  endproperty
  a_term_stay: assert property (p_term_stay)
    else $error("power-down left without a valid exit");
  property p_deep_soft;
    (cs_rise && r.pwr == fplsc_pkg::PW_DEEP && r.opcode == 8'h99 &&
     !jedec_rst && !pin_rst) |=> (r.pwr == fplsc_pkg::PW_DEEP);
  endproperty
  a_deep_soft: assert property (p_deep_soft)
    else $error("soft reset left deepest level");
  property p_term_halt;
    (exec1 && r.opcode == 8'hf0 && r.prog_act && !r.prog_pause && !pd_now &&
     !jedec_rst && !pin_rst) |=> (!r.prog_act && r.pe && !pd_now);
  endproperty
  a_term_halt: assert property (p_term_halt)
    else $error("terminate did not halt program");
  property p_pd_quiet;
    (r.pwr == fplsc_pkg::PW_LIGHT || r.pwr == fplsc_pkg::PW_DEEP)
    |-> !so_oe;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("so driven during power-down");
  property p_any_suspend_flag_read;
    (psel && !penable && paddr == 32'h0000_0000)
    |=> (prdata[7] == ($past(r.es) | $past(r.ps)));
  endproperty
  a_any_suspend_flag_read: assert property (p_any_suspend_flag_read)
    else $error("suspend flag not or of erase and program flags");
endmodule
`default_nettype wire

// [tb/fplsc_spi_host.sv]
// spi host model: mode 0 frames with clock running only inside frames
`timescale 1ns/1ps
`default_nettype none
module fplsc_spi_host (
  input  wire logic pclk,
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe
);
  // idle levels: deselected, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // one frame: opcode then 24-bit address, msb first; so read on high phase
  task automatic frame(input logic [31:0] bits, input int nck,
                       output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    @(posedge pclk);
    cs_n <= 1'b0;
    for (int i = 0; i < nck; i++) begin
      si <= (i < 32) ? bits[31 - (i % 32)] : 1'b0;
      repeat (4) @(posedge pclk);
      sck <= 1'b1;
      // sample late in the high half, device updates so after the fall
      repeat (4) @(posedge pclk);
      // a released so line reads inverted, so a lost drive shows up
      if (i >= 32) rx = {rx[6:0], so_oe ? so : ~so};
      oe = oe | so_oe;
      sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    cs_n <= 1'b1;
    // gap keeps deselect longer than the sync depth
    repeat (12) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// [tb/fplsc_top_bench.sv]
// testbench: apb register access plus spi command sequences
`timescale 1ns/1ps
`default_nettype none
module fplsc_top_bench;
  localparam int DWAKE = 20;
  localparam logic [11:0] S2 = fplsc_pkg::STAT2_OFS;
  localparam logic [11:0] S3 = fplsc_pkg::STAT3_OFS;
  localparam logic [11:0] S4 = fplsc_pkg::STAT4_OFS;
  localparam logic [11:0] S5 = fplsc_pkg::STAT5_OFS;
  localparam logic [11:0] LK = fplsc_pkg::LOCK_OFS;
  localparam logic [11:0] RP = fplsc_pkg::RSTPWR_OFS;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        reset_pin_n = 1'b1;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic [7:0]  rx;
  logic        oe;
  logic [31:0] v;
  logic        e;
  int          n_errors = 0;
  int          check_count = 0;

  // 4 ns clock
  always #2 pclk = ~pclk;

  fplsc_top #(.DEEP_WAKE_CYC(DWAKE)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
    .si(si), .reset_pin_n(reset_pin_n), .so(so), .so_oe(so_oe)
  );

  fplsc_spi_host i_host (
    .pclk(pclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // setup then access phase, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0, v, e);
    chk(v & m, x);
  endtask

  // bounded poll: reads repeat until the masked value matches or n reads are done
  task automatic pw(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] x, input int n);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0, v, e);
      k++;
    end while ((v & m) !== x && k < n);
    chk(v & m, x);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input int n);
    i_host.frame({op, a}, n, rx, oe);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rc(LK, 32'hffffffff, {16'h0, fplsc_pkg::LOCK_RST});
    rc(S4, 32'hffffffff, 32'h0);
    apb(1'b0, 12'h040, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    wr(LK, 32'h0002);
    cmd(fplsc_pkg::OP_LOCK_A, 24'h010000, 40);
    chk({24'h0, rx}, 32'h01);
    cmd(fplsc_pkg::OP_LOCK_B, 24'h010000, 40);
    chk({24'h0, rx}, 32'h01);
    cmd(fplsc_pkg::OP_LOCK_B, 24'h000000, 40);
    chk({24'h0, rx}, 32'h00);
    $display("test lock done");
    cmd(8'h60, 24'h000000, 32);
    rc(RP, 32'h10, 32'h0);
    cmd(8'h02, 24'h010000, 32);
    rc(RP, 32'h10, 32'h0);
    cmd(8'h02, 24'h000000, 32);
    rc(RP, 32'h10, 32'h10);
    cmd(fplsc_pkg::OP_RST_EN, 24'h0, 8);
    cmd(fplsc_pkg::OP_RST, 24'h0, 8);
    rc(RP, 32'h10, 32'h0);
    cmd(8'hd8, 24'h000000, 32);
    rc(RP, 32'h10, 32'h10);
    cmd(fplsc_pkg::OP_TERM, 24'h0, 8);
    rc(RP, 32'h10, 32'h0);
    rc(S4, 32'h10, 32'h10);
    cmd(8'h02, 24'h000000, 32);
    cmd(fplsc_pkg::OP_TERM, 24'h0, 8);
    rc(RP, 32'h10, 32'h0);
    rc(S4, 32'h30, 32'h30);
    $display("test program erase done");
    wr(S4, 32'h80);
    cmd(fplsc_pkg::OP_PD, 24'h0, 8);
    rc(RP, 32'h3, 32'h1);
    cmd(fplsc_pkg::OP_TERM, 24'h0, 8);
    rc(RP, 32'h3, 32'h1);
    cmd(fplsc_pkg::OP_LOCK_A, 24'h010000, 40);
    chk({31'h0, oe}, 32'h0);
    cmd(fplsc_pkg::OP_RESUME, 24'h0, 8);
    pw(RP, 32'h3, 32'h0, 400);
    rc(S4, 32'hb0, 32'hb0);
    wr(S4, 32'h0);
    cmd(fplsc_pkg::OP_PD, 24'h0, 8);
    rc(RP, 32'h3, 32'h3);
    cmd(fplsc_pkg::OP_RST_EN, 24'h0, 8);
    cmd(fplsc_pkg::OP_RST, 24'h0, 8);
    rc(RP, 32'h3, 32'h3);
    cmd(fplsc_pkg::OP_RESUME, 24'h0, 8);
    pw(RP, 32'h3, 32'h0, 100);
    rc(S4, 32'h30, 32'h0);
    wr(S4, 32'h80);
    cmd(fplsc_pkg::OP_PD, 24'h0, 8);
    cmd(fplsc_pkg::OP_RST_EN, 24'h0, 8);
    cmd(fplsc_pkg::OP_RST, 24'h0, 8);
    pw(RP, 32'h3, 32'h0, 400);
    wr(S4, 32'h80);
    cmd(fplsc_pkg::OP_PD_DEEP, 24'h0, 8);
    rc(RP, 32'h3, 32'h3);
    wr(RP, 32'h1);
    pw(RP, 32'h3, 32'h0, 100);
    wr(S3, 32'h80);
    cmd(fplsc_pkg::OP_PD_DEEP, 24'h0, 8);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    reset_pin_n <= 1'b1;
    pw(RP, 32'h3, 32'h0, 100);
    $display("test power-down done");
    // erase suspended before program, never the other way round
    cmd(8'hd8, 24'h000000, 32);
    cmd(fplsc_pkg::OP_ANY_SUSPEND_FLAG_A, 24'h0, 8);
    rc(S5, 32'hc, 32'h8);
    rc(S2, 32'h80, 32'h80);
    cmd(8'h02, 24'h000000, 32);
    cmd(fplsc_pkg::OP_ANY_SUSPEND_FLAG_B, 24'h0, 8);
    rc(S5, 32'hc, 32'hc);
    cmd(fplsc_pkg::OP_RESM_A, 24'h0, 8);
    pw(S5, 32'hc, 32'h8, 400);
    rc(S2, 32'h80, 32'h80);
    cmd(fplsc_pkg::OP_RESM_B, 24'h0, 8);
    pw(S5, 32'hc, 32'h0, 1000);
    rc(S2, 32'h80, 32'h0);
    $display("test suspend done");
    finish_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
